/* design/adc_aux_function_control.sv */
// auxiliary pins, conversion sequencing, result shaping and error flags of the converter
// How it works
// - input-enabled bidir pin level lands in level bit
// - output-enabled pins drive their level bit unless also input-enabled
// - bidir pins own enables; upper pair shares one
// - fault function 11 makes it a plain output
// - mux timing latches pin levels at conversion start
// - three-bit code selects one of eight delays
// - delay without hiding lengthens every conversion
// - hiding trims filter averaging by the delay
// - hiding only for slow, non-excluded data rates
// - short-result bit rounds results to 16 bits
// - dout pin shows ready, data during reads
// - hold bit keeps data until chip select rises
// - sync low holds modulator and filter reset
// - release on the fifth clock edge after sync rises, once synchronised
// - sync rise starts conversion, ready falls after
// - sequenced sync waits for sync before next channel
// - range error flag and saturated result codes
// - checksum error clears on status read
// - register check flags changes of watched registers
// - clearing register check clears register error
// - error output drives low on any flag
// - error input ORs into conversion error flag
//
// Implementation choices: the register addresses and the address-and-strobe port.
module adc_aux_function_control
  import adc_aux_pkg::*;
#(
  parameter int DELAY_US [8] = '{0, 4, 16, 40, 100, 200, 500, 1000},
  parameter logic [4:0] ODR_FIRST_SLOW = 5'h07,
  parameter logic [4:0] NO_HIDE_A = 5'h0D,
  parameter logic [4:0] NO_HIDE_B = 5'h0F,
  parameter logic [4:0] NO_HIDE_C = 5'h10,
  parameter logic [4:0] NO_HIDE_D = 5'h13
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [23:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [23:0] reg_rdata,
  // general pins
  input wire logic bidir_pin_zero_in,
  output logic bidir_pin_zero_out,
  output logic bidir_pin_zero_oe_n,
  input wire logic bidir_pin_one_in,
  output logic bidir_pin_one_out,
  output logic bidir_pin_one_oe_n,
  output logic out_pin_two,
  output logic out_pin_three,
  // fault pin, open drain when reporting errors
  input wire logic fault_pin_in,
  output logic fault_pin_out,
  output logic fault_pin_oe_n,
  // sync, chip select and shared data/ready pin
  input wire logic sync_n_pin,
  input wire logic cs_n_pin,
  output logic dout_rdy_pin,
  // serial core
  input wire logic serial_dout,
  input wire logic read_active,
  input wire logic crc_mismatch,
  // converter core
  input wire logic combined_filter_sel,
  input wire logic [4:0] odr_sel,
  input wire logic [23:0] conv_time_cycles,
  input wire logic core_done,
  input wire conv_result_t core_result,
  output logic core_reset,
  output logic sample_start,
  output logic channel_advance,
  output logic [CNT_W-1:0] average_trim_cycles
);

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!resetn);

  // ----------------------------------------------------------------
  // pin input synchronisers
  // ----------------------------------------------------------------
  logic [IN_COUNT-1:0] pins_raw;
  logic [IN_COUNT-1:0] s1;
  logic [IN_COUNT-1:0] s2;
  logic [IN_COUNT-1:0] s3;
  logic [IN_COUNT-1:0] stable;

  assign pins_raw = {cs_n_pin, sync_n_pin, fault_pin_in, bidir_pin_one_in, bidir_pin_zero_in};

  for (genvar i = 0; i < IN_COUNT; i++)
  begin : g_sync
    always_ff @(posedge clk_sys)
    begin
      if (!resetn)
      begin
        s1[i] <= IN_IDLE[i];
        s2[i] <= IN_IDLE[i];
        s3[i] <= IN_IDLE[i];
        stable[i] <= IN_IDLE[i];
      end
      else
      begin
        s1[i] <= pins_raw[i];
        s2[i] <= s1[i];
        s3[i] <= s2[i];
        if (s2[i] == s3[i])
          stable[i] <= s3[i];
      end
    end
  end

  // ----------------------------------------------------------------
  // registers and decode
  // ----------------------------------------------------------------
  logic [15:0] mode;
  logic [15:0] ifmode;
  logic [15:0] pincfg;
  logic [15:0] next_pincfg;
  logic [23:0] data_reg;
  logic [3:0] channel;
  logic ready_n;
  logic range_flag;
  logic crc_err;
  logic reg_err;
  logic [15:0] sig_ref;

  wire wr_mode = reg_wr && reg_addr == REG_MODE;
  wire wr_ifmode = reg_wr && reg_addr == REG_IFMODE;
  wire wr_pincfg = reg_wr && reg_addr == REG_PINCFG;
  wire rd_status = reg_rd && reg_addr == REG_STATUS;
  wire rd_data = reg_rd && reg_addr == REG_DATA;
  wire [1:0] err_mode = pincfg[PC_ERR_LSB +: 2];
  wire sync_lvl = stable[IN_SYNC];
  wire cs_high = stable[IN_CS];
  wire ext_err = err_mode == ERR_IN && !stable[IN_FAULT];
  wire adc_err = range_flag || ext_err;
  wire any_err = adc_err || crc_err || reg_err;
  wire [7:0] status = {ready_n, adc_err, crc_err, reg_err, channel};
  wire [23:0] read_mux = (reg_addr == REG_STATUS) ? {16'h0000, status} :
                         (reg_addr == REG_MODE) ? {8'h00, mode} :
                         (reg_addr == REG_IFMODE) ? {8'h00, ifmode} :
                         (reg_addr == REG_DATA) ? data_reg :
                         (reg_addr == REG_PINCFG) ? {8'h00, pincfg} : 24'h00_0000;

  // input-enabled pins overwrite their level bits; no enable leaves them alone
  always_comb
  begin
    next_pincfg = wr_pincfg ? reg_wdata[15:0] : pincfg;
    if (next_pincfg[PC_IN_EN0])
      next_pincfg[IN_PIN0] = stable[IN_PIN0];
    if (next_pincfg[PC_IN_EN1])
      next_pincfg[IN_PIN1] = stable[IN_PIN1];
    if (next_pincfg[PC_ERR_LSB +: 2] == ERR_IN)
      next_pincfg[PC_FAULT_LEVEL] = stable[IN_FAULT];
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      mode <= MODE_RESET;
      ifmode <= IFMODE_RESET;
      pincfg <= PINCFG_RESET;
      reg_rdata <= 24'h00_0000;
    end
    else
    begin
      if (wr_mode)
        mode <= reg_wdata[15:0];
      if (wr_ifmode)
        ifmode <= reg_wdata[15:0];
      pincfg <= next_pincfg;
      reg_rdata <= reg_rd ? read_mux : 24'h00_0000;
    end
  end

  p_level_in_a: assert property ((pincfg[PC_IN_EN0] && !wr_pincfg) |=>
    pincfg[IN_PIN0] == $past(stable[IN_PIN0])) else $error("input pin level not captured");

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  seq_state_t state;
  seq_state_t next_state;
  logic [CNT_W-1:0] delay_cnt;
  logic [CNT_W-1:0] delay_cyc;

  wire sequenced_sync_select = ifmode[IF_SEQ_SYNC];
  wire hold_req = pincfg[PC_SYNC_EN] && !sequenced_sync_select && !sync_lvl;
  wire [2:0] delay_code = mode[MD_DELAY_LSB +: 3];
  wire odr_ok = odr_sel >= ODR_FIRST_SLOW && odr_sel != NO_HIDE_A && odr_sel != NO_HIDE_B &&
                odr_sel != NO_HIDE_C && odr_sel != NO_HIDE_D;
  wire half_ok = {7'h00, delay_cyc, 1'b0} < conv_time_cycles;
  wire hide_ok = combined_filter_sel && mode[MD_HIDE_DELAY] && half_ok && odr_ok;
  wire load_delay = next_state == SEQ_DELAY && state != SEQ_DELAY;
  wire res_take = core_done && state == SEQ_CONVERT;

  assign delay_cyc = CNT_W'(DELAY_US[delay_code] * CLK_FREQ_MHZ);
  assign core_reset = state == SEQ_HOLD;

  always_comb
  begin
    next_state = state;
    case (state)
      SEQ_HOLD:
        if (!hold_req)
          next_state = SEQ_DELAY;
      SEQ_DELAY:
        if (delay_cnt == '0)
          next_state = SEQ_CONVERT;
      SEQ_CONVERT:
        if (core_done)
          next_state = (sequenced_sync_select && !sync_lvl) ? SEQ_WAIT_SYNC : SEQ_DELAY;
      SEQ_WAIT_SYNC:
        if (sync_lvl)
          next_state = SEQ_DELAY;
      default:
        next_state = SEQ_HOLD;
    endcase
    if (hold_req)
      next_state = SEQ_HOLD;
  end

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      state <= SEQ_HOLD;
      delay_cnt <= '0;
      sample_start <= 1'b0;
      channel_advance <= 1'b0;
      average_trim_cycles <= '0;
    end
    else
    begin
      state <= next_state;
      if (load_delay)
      begin
        delay_cnt <= delay_cyc;
        average_trim_cycles <= hide_ok ? delay_cyc : '0;
      end
      else if (state == SEQ_DELAY && delay_cnt != '0)
        delay_cnt <= delay_cnt - 1'b1;
      sample_start <= state == SEQ_DELAY && next_state == SEQ_CONVERT;
      channel_advance <= res_take;
    end
  end

  p_delay_end_a: assert property (sample_start |-> $past(state) == SEQ_DELAY && $past(delay_cnt) == '0)
    else $error("sampling started before delay ran out");
  p_delay_step_a: assert property ((state == SEQ_DELAY && delay_cnt != '0 && !hold_req) |=>
                                   state == SEQ_DELAY && delay_cnt == $past(delay_cnt) - 1'b1)
    else $error("delay count did not step");
  p_no_hide_a: assert property ((load_delay && (odr_sel == NO_HIDE_A || odr_sel < ODR_FIRST_SLOW)) |=>
                                average_trim_cycles == '0)
    else $error("delay hidden at a rate that cannot absorb it");
  p_sync_hold_a: assert property (hold_req |=> state == SEQ_HOLD && core_reset)
    else $error("sync low did not hold the core");
  p_alt_wait_a: assert property ((state == SEQ_WAIT_SYNC && !sync_lvl && !hold_req) |=>
    state == SEQ_WAIT_SYNC) else $error("next channel started while sync low");

  // ----------------------------------------------------------------
  // result shaping and error flags
  // ----------------------------------------------------------------
  logic [16:0] rounded;
  logic [23:0] saturated;
  logic [15:0] reg_sig;

  assign saturated = core_result.over ? 24'hFF_FFFF : core_result.under ? 24'h00_0000 : core_result.value;
  assign rounded = {1'b0, saturated[23:8]} + {16'h0000, saturated[7]};
  assign reg_sig = mode ^ (pincfg & PINCFG_WATCH);

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      data_reg <= 24'h00_0000;
      channel <= 4'h0;
      ready_n <= 1'b1;
      range_flag <= 1'b0;
      crc_err <= 1'b0;
      reg_err <= 1'b0;
      sig_ref <= 16'h0000;
    end
    else
    begin
      if (res_take)
      begin
        if (ifmode[IF_SHORT])
          data_reg <= {8'h00, rounded[16] ? 16'hFFFF : rounded[15:0]};
        else
          data_reg <= saturated;
        channel <= core_result.channel;
        range_flag <= core_result.over || core_result.under;
      end
      if (res_take)
        ready_n <= 1'b0;
      else if (rd_data)
        ready_n <= 1'b1;
      if (crc_mismatch)
        crc_err <= 1'b1;
      else if (rd_status)
        crc_err <= 1'b0;
      if (!ifmode[IF_REG_CHECK])
      begin
        reg_err <= 1'b0;
        sig_ref <= reg_sig;
      end
      else if (reg_sig != sig_ref)
        reg_err <= 1'b1;
    end
  end

  p_short_a: assert property ((res_take && ifmode[IF_SHORT]) |=> data_reg[23:16] == 8'h00)
    else $error("short result wider than 16 bits");
  p_saturate_a: assert property ((res_take && core_result.over) |=>
                                 data_reg == ($past(ifmode[IF_SHORT]) ? 24'h00_FFFF : 24'hFF_FFFF) && range_flag)
    else $error("overrange result not saturated");
  p_crc_clear_a: assert property ((rd_status && !crc_mismatch) |=> !crc_err)
    else $error("checksum error survived status read");
  p_crc_set_a: assert property (crc_mismatch |=> crc_err [*1] ##0 status[ST_CRC_ERR])
    else $error("checksum error not flagged");
  p_reg_clear_a: assert property (!ifmode[IF_REG_CHECK] |=> !reg_err)
    else $error("register error not cleared");

  // ----------------------------------------------------------------
  // pin drivers
  // ----------------------------------------------------------------
  logic [3:0] mux_level;
  logic dout_data;
  logic [REVERT_W-1:0] revert_cnt;

  wire mux_timing = pincfg[PC_MUX_TIMING];
  wire [3:0] pin_src = mux_timing ? mux_level : pincfg[3:0];
  wire drive0 = pincfg[PC_OUT_EN0] && !pincfg[PC_IN_EN0];
  wire drive1 = pincfg[PC_OUT_EN1] && !pincfg[PC_IN_EN1];
  wire upper_en = pincfg[PC_UPPER_EN];
  wire fault_drive = err_mode == ERR_GPO || (err_mode == ERR_OUT && any_err);

  always_ff @(posedge clk_sys)
  begin
    if (!resetn)
    begin
      mux_level <= 4'h0;
      bidir_pin_zero_out <= 1'b0;
      bidir_pin_zero_oe_n <= 1'b1;
      bidir_pin_one_out <= 1'b0;
      bidir_pin_one_oe_n <= 1'b1;
      out_pin_two <= 1'b0;
      out_pin_three <= 1'b0;
      fault_pin_out <= 1'b0;
      fault_pin_oe_n <= 1'b1;
      dout_data <= 1'b0;
      revert_cnt <= '0;
      dout_rdy_pin <= 1'b1;
    end
    else
    begin
      if (load_delay)
        mux_level <= pincfg[3:0];
      bidir_pin_zero_out <= drive0 && pin_src[0];
      bidir_pin_zero_oe_n <= !drive0;
      bidir_pin_one_out <= drive1 && pin_src[1];
      bidir_pin_one_oe_n <= !drive1;
      out_pin_two <= upper_en && pin_src[2];
      out_pin_three <= upper_en && pin_src[3];
      fault_pin_out <= err_mode == ERR_GPO && pincfg[PC_FAULT_LEVEL];
      fault_pin_oe_n <= !fault_drive;
      if (read_active)
      begin
        dout_data <= 1'b1;
        revert_cnt <= REVERT_W'(DOUT_REVERT_CYC);
      end
      else if (dout_data)
      begin
        if (ifmode[IF_DOUT_HOLD])
          dout_data <= !cs_high;
        else if (revert_cnt <= 1)
          dout_data <= 1'b0;
        else
          revert_cnt <= revert_cnt - 1'b1;
      end
      dout_rdy_pin <= dout_data ? serial_dout : ready_n;
    end
  end

  p_pin_drive_a: assert property ((drive0 && !mux_timing) |=> !bidir_pin_zero_oe_n &&
                                  bidir_pin_zero_out == $past(pincfg[0]))
    else $error("output pin not at its level bit");
  p_upper_pins_a: assert property (!upper_en |=> !out_pin_two && !out_pin_three)
    else $error("upper outputs driven while disabled");
  p_fault_gpo_a: assert property ((err_mode == ERR_GPO) |=> !fault_pin_oe_n &&
                                  fault_pin_out == $past(pincfg[PC_FAULT_LEVEL]))
    else $error("fault pin not following its level bit");
  p_fault_low_a: assert property ((err_mode == ERR_OUT && any_err) |=> !fault_pin_oe_n && !fault_pin_out)
    else $error("error output not pulled low");
  p_mux_hold_a: assert property ((mux_timing && !load_delay) |=> $stable(mux_level))
    else $error("mux levels changed outside a channel change");
  p_dout_hold_a: assert property ((dout_data && !read_active && ifmode[IF_DOUT_HOLD] && !cs_high) |=>
    dout_data) else $error("data phase ended before chip select rose");

endmodule // adc_aux_function_control

/* design/adc_aux_pkg.sv */
// constants, types and register layout shared by the auxiliary function block
package adc_aux_pkg;

  // ----------------------------------------------------------------
  // clock and timing
  // ----------------------------------------------------------------
  localparam int CLK_FREQ_MHZ = 40;
  localparam int DOUT_REVERT_NS = 10;
  localparam int DOUT_REVERT_RAW = (DOUT_REVERT_NS * CLK_FREQ_MHZ + 999) / 1000;
  localparam int DOUT_REVERT_CYC = (DOUT_REVERT_RAW < 1) ? 1 : DOUT_REVERT_RAW;
  localparam int CNT_W = 16;
  localparam int REVERT_W = 4;

  // ----------------------------------------------------------------
  // register indexes
  // ----------------------------------------------------------------
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_MODE = 8'h01;
  localparam logic [7:0] REG_IFMODE = 8'h02;
  localparam logic [7:0] REG_DATA = 8'h04;
  localparam logic [7:0] REG_PINCFG = 8'h06;

  // status fields
  localparam int ST_READY_N = 7;
  localparam int ST_ADC_ERR = 6;
  localparam int ST_CRC_ERR = 5;
  localparam int ST_REG_ERR = 4;

  // mode fields
  localparam int MD_HIDE_DELAY = 14;
  localparam int MD_DELAY_LSB = 8;
  localparam logic [15:0] MODE_RESET = 16'hA000;

  // interface mode fields
  localparam int IF_SEQ_SYNC = 12;
  localparam int IF_DOUT_HOLD = 8;
  localparam int IF_REG_CHECK = 5;
  localparam int IF_SHORT = 0;
  localparam logic [15:0] IFMODE_RESET = 16'h0000;

  // pin configuration fields
  localparam int PC_IN_EN0 = 4;
  localparam int PC_IN_EN1 = 5;
  localparam int PC_OUT_EN0 = 6;
  localparam int PC_OUT_EN1 = 7;
  localparam int PC_FAULT_LEVEL = 8;
  localparam int PC_ERR_LSB = 9;
  localparam int PC_SYNC_EN = 11;
  localparam int PC_MUX_TIMING = 12;
  localparam int PC_UPPER_EN = 13;
  localparam logic [15:0] PINCFG_RESET = 16'h0800;
  localparam logic [15:0] PINCFG_WATCH = 16'hFEFC;

  // fault pin functions
  localparam logic [1:0] ERR_OFF = 2'b00;
  localparam logic [1:0] ERR_IN = 2'b01;
  localparam logic [1:0] ERR_OUT = 2'b10;
  localparam logic [1:0] ERR_GPO = 2'b11;

  // synchronised pin inputs
  localparam int IN_PIN0 = 0;
  localparam int IN_PIN1 = 1;
  localparam int IN_FAULT = 2;
  localparam int IN_SYNC = 3;
  localparam int IN_CS = 4;
  localparam int IN_COUNT = 5;
  localparam logic [4:0] IN_IDLE = 5'b1_1100;

  typedef struct packed {
    logic over;
    logic under;
    logic [3:0] channel;
    logic [23:0] value;
  } conv_result_t;

  typedef enum logic [1:0] {SEQ_HOLD, SEQ_DELAY, SEQ_CONVERT, SEQ_WAIT_SYNC} seq_state_t;

endpackage

/* verification/adc_aux_function_control_tb.sv */
// self-checking bench for the auxiliary function block
`define CHK(nm, e, g) begin total_checks++; if ((g) !== (e)) begin errors++; \
  $display("mismatch %s exp %h got %h", nm, e, g); end end
`define WAITC(nm, s) begin n = 0; while ((s) !== 1'b1 && n < 400) begin \
  @(posedge clk_sys); n++; end `CHK(nm, 1'b1, s) end
module adc_aux_function_control_tb
  import adc_aux_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;
  localparam int DUS [8] = '{0, 1, 2, 0, 1, 0, 2, 1};
  localparam logic [7:0] RA [5] = '{REG_STATUS, REG_MODE, REG_IFMODE, REG_PINCFG, 8'h3F};
  localparam logic [15:0] RV [5] = '{16'h0080, MODE_RESET, IFMODE_RESET, PINCFG_RESET, 16'h0000};
  localparam logic [7:0] HCOMB = 8'b1011_1111;
  localparam logic [4:0] HODR [8] = '{5'h07, 5'h0D, 5'h0F, 5'h10, 5'h13, 5'h06, 5'h07, 5'h07};
  logic clk_sys = 1'b0;
  logic resetn = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [23:0] reg_wdata = 24'h00_0000;
  logic reg_wr = 1'b0, reg_rd = 1'b0;
  logic [23:0] reg_rdata, v;
  logic p0_ext = 1'b0, p1_ext = 1'b0, fault_ext = 1'b1;
  logic p0_out, p0_oe_n, p1_out, p1_oe_n, pin2, pin3, f_out, f_oe_n;
  logic sync_n, cs_n = 1'b1, dout_pin, sync_low_req = 1'b0;
  logic serial_dout = 1'b0, read_active = 1'b0, crc_mismatch = 1'b0;
  logic comb_sel = 1'b0;
  logic [4:0] odr_sel = 5'h00;
  logic [23:0] conv_time = 24'h00_03E8;
  logic core_done, core_reset, sample_start, ch_adv;
  logic [CNT_W-1:0] trim;
  conv_result_t core_result;
  conv_result_t next_result = '{1'b0, 1'b0, 4'h2, 24'h12_3480};
  int errors = 0, total_checks = 0, cycles = 0, n, g;
  // open-drain fault line with pull-up, bidir pins resolved from enables
  wire p0_wire = p0_oe_n ? p0_ext : p0_out;
  wire p1_wire = p1_oe_n ? p1_ext : p1_out;
  wire f_wire = (f_oe_n ? 1'b1 : f_out) & fault_ext;

  always #12.5 clk_sys = ~clk_sys;

  adc_aux_function_control #(.DELAY_US(DUS)) dut (
    .clk_sys(clk_sys), .resetn(resetn),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .bidir_pin_zero_in(p0_wire), .bidir_pin_zero_out(p0_out), .bidir_pin_zero_oe_n(p0_oe_n),
    .bidir_pin_one_in(p1_wire), .bidir_pin_one_out(p1_out), .bidir_pin_one_oe_n(p1_oe_n),
    .out_pin_two(pin2), .out_pin_three(pin3),
    .fault_pin_in(f_wire), .fault_pin_out(f_out), .fault_pin_oe_n(f_oe_n),
    .sync_n_pin(sync_n), .cs_n_pin(cs_n), .dout_rdy_pin(dout_pin),
    .serial_dout(serial_dout), .read_active(read_active), .crc_mismatch(crc_mismatch),
    .combined_filter_sel(comb_sel), .odr_sel(odr_sel), .conv_time_cycles(conv_time),
    .core_done(core_done), .core_result(core_result), .core_reset(core_reset),
    .sample_start(sample_start), .channel_advance(ch_adv), .average_trim_cycles(trim)
  );

  host_side_model #(.CONV_LAT(24)) host (
    .clk_sys(clk_sys), .resetn(resetn), .sync_low_req(sync_low_req),
    .next_result(next_result), .sample_start(sample_start), .sync_n_pin(sync_n),
    .core_done(core_done), .core_result(core_result)
  );

  // ----------------------------------------------------------------
  // bus tasks and helpers
  // ----------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [23:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk_sys);
    reg_wr <= 1'b0;
    @(posedge clk_sys);
  endtask

  task automatic rd(input logic [7:0] a);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clk_sys);
    reg_rd <= 1'b0;
    @(posedge clk_sys);
    v = reg_rdata;
  endtask

  task automatic rdc(input logic [7:0] a, input logic [23:0] m, input logic [23:0] e);
    rd(a);
    `CHK($sformatf("reg %h", a), e, v & m)
  endtask

  task automatic next_conv();
    `WAITC("adv", ch_adv)
    @(posedge clk_sys);
    `WAITC("adv", ch_adv)
  endtask

  // edges from channel advance to the next sampling start, less one
  task automatic gap();
    `WAITC("adv", ch_adv)
    g = 0;
    @(posedge clk_sys);
    while (sample_start !== 1'b1 && g < 400)
    begin
      @(posedge clk_sys);
      g++;
    end
  endtask

  task automatic count_starts(input int c);
    n = 0;
    repeat (c)
    begin
      @(posedge clk_sys);
      if (sample_start === 1'b1)
        n++;
    end
  endtask

  task automatic done(input string s);
    $display("test %s finished", s);
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", total_checks, errors);
    if (errors == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // tests
  // ----------------------------------------------------------------
  initial
  begin
    repeat (16) @(posedge clk_sys);
    resetn <= 1'b1;
    @(posedge clk_sys);
    wr(REG_STATUS, 24'h00_00FF);
    foreach (RA[i]) rdc(RA[i], 24'hFF_FFFF, {8'h00, RV[i]});
    done("reset");
    wr(REG_PINCFG, 24'h00_28C9);
    repeat (2) @(posedge clk_sys);
    `CHK("pins", 6'b10_0001, {p0_out, p0_oe_n, p1_out, p1_oe_n, pin2, pin3})
    p0_ext <= 1'b1;
    wr(REG_PINCFG, 24'h00_0830);
    repeat (6) @(posedge clk_sys);
    rdc(REG_PINCFG, 24'h00_00FF, 24'h00_0031);
    wr(REG_PINCFG, 24'h00_080E);
    repeat (6) @(posedge clk_sys);
    rdc(REG_PINCFG, 24'h00_00FF, 24'h00_000E);
    `CHK("idle pins", 4'b1100, {p0_oe_n, p1_oe_n, pin2, pin3})
    // mux timing: the new level waits for the next conversion start
    `WAITC("adv", ch_adv)
    wr(REG_PINCFG, 24'h00_1841);
    repeat (2) @(posedge clk_sys);
    `CHK("mux hold", 2'b00, {p0_out, p0_oe_n})
    `WAITC("adv", ch_adv)
    @(posedge clk_sys);
    `CHK("mux step", 2'b10, {p0_out, p0_oe_n})
    done("pins");
    wr(REG_PINCFG, 24'h00_0F00);
    repeat (2) @(posedge clk_sys);
    `CHK("gpo", 2'b10, {f_out, f_oe_n})
    wr(REG_PINCFG, 24'h00_0E00);
    repeat (2) @(posedge clk_sys);
    `CHK("gpo", 2'b00, {f_out, f_oe_n})
    fault_ext <= 1'b0;
    wr(REG_PINCFG, 24'h00_0A00);
    repeat (6) @(posedge clk_sys);
    rdc(REG_STATUS, 24'h00_0040, 24'h00_0040);
    rdc(REG_PINCFG, 24'h00_0100, 24'h00_0000);
    fault_ext <= 1'b1;
    repeat (6) @(posedge clk_sys);
    rdc(REG_STATUS, 24'h00_0040, 24'h00_0000);
    rdc(REG_PINCFG, 24'h00_0100, 24'h00_0100);
    done("fault pin");
    wr(REG_PINCFG, 24'h00_0C00);
    crc_mismatch <= 1'b1;
    @(posedge clk_sys);
    crc_mismatch <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("err out", 2'b00, {f_wire, f_oe_n})
    rdc(REG_STATUS, 24'h00_0020, 24'h00_0020);
    rdc(REG_STATUS, 24'h00_0020, 24'h00_0000);
    `CHK("err out", 1'b1, f_oe_n)
    wr(REG_IFMODE, 24'h00_0020);
    repeat (3) @(posedge clk_sys);
    rdc(REG_STATUS, 24'h00_0010, 24'h00_0000);
    wr(REG_MODE, 24'h00_A100);
    repeat (3) @(posedge clk_sys);
    rdc(REG_STATUS, 24'h00_0010, 24'h00_0010);
    wr(REG_IFMODE, 24'h00_0000);
    repeat (2) @(posedge clk_sys);
    rdc(REG_STATUS, 24'h00_0010, 24'h00_0000);
    done("error flags");
    wr(REG_MODE, 24'h00_A000);
    next_conv();
    rdc(REG_DATA, 24'hFF_FFFF, 24'h12_3480);
    wr(REG_IFMODE, 24'h00_0001);
    next_conv();
    rdc(REG_DATA, 24'hFF_FFFF, 24'h00_1235);
    next_result <= '{1'b0, 1'b0, 4'h2, 24'h12_347F};
    next_conv();
    rdc(REG_DATA, 24'hFF_FFFF, 24'h00_1234);
    wr(REG_IFMODE, 24'h00_0000);
    next_result <= '{1'b1, 1'b0, 4'h2, 24'h00_1234};
    next_conv();
    rdc(REG_DATA, 24'hFF_FFFF, 24'hFF_FFFF);
    rdc(REG_STATUS, 24'h00_00C0, 24'h00_00C0);
    next_result <= '{1'b0, 1'b1, 4'h2, 24'h12_3480};
    next_conv();
    rdc(REG_DATA, 24'hFF_FFFF, 24'h00_0000);
    next_result <= '{1'b0, 1'b0, 4'h2, 24'h12_3480};
    next_conv();
    rdc(REG_STATUS, 24'h00_00C0, 24'h00_0000);
    done("results");
    sync_low_req <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `CHK("held", 1'b1, core_reset)
    count_starts(40);
    `CHK("held starts", 0, n)
    sync_low_req <= 1'b0;
    `WAITC("start", sample_start)
    `CHK("release", 1'b1, n < 10)
    done("sync");
    for (int c = 0; c < 8; c++)
    begin
      wr(REG_MODE, 24'h00_A000 | (24'(c) << 8));
      next_conv();
      gap();
      `CHK("delay", DUS[c] * 40, g)
    end
    wr(REG_MODE, 24'h00_E200);
    for (int k = 0; k < 8; k++)
    begin
      comb_sel <= HCOMB[k];
      odr_sel <= HODR[k];
      conv_time <= (k == 7) ? 24'h00_0064 : 24'h00_03E8;
      next_conv();
      `CHK("trim", (k == 0) ? 16'h0050 : 16'h0000, trim)
    end
    done("delay");
    wr(REG_MODE, 24'h00_A000);
    sync_low_req <= 1'b1;
    repeat (40) @(posedge clk_sys);
    rd(REG_DATA);
    read_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    `CHK("dout data", 1'b0, dout_pin)
    read_active <= 1'b0;
    repeat (2) @(posedge clk_sys);
    `CHK("dout data", 1'b0, dout_pin)
    repeat (2) @(posedge clk_sys);
    `CHK("dout ready", 1'b1, dout_pin)
    wr(REG_IFMODE, 24'h00_0100);
    cs_n <= 1'b0;
    repeat (4) @(posedge clk_sys);
    read_active <= 1'b1;
    repeat (3) @(posedge clk_sys);
    read_active <= 1'b0;
    repeat (10) @(posedge clk_sys);
    `CHK("dout hold", 1'b0, dout_pin)
    cs_n <= 1'b1;
    `WAITC("dout cs", dout_pin)
    `CHK("dout cs", 1'b1, n < 9)
    sync_low_req <= 1'b0;
    done("dout");
    wr(REG_IFMODE, 24'h00_1000);
    next_result <= '{1'b0, 1'b0, 4'h5, 24'h12_3480};
    sync_low_req <= 1'b1;
    repeat (8) @(posedge clk_sys);
    `WAITC("finish", ch_adv)
    count_starts(60);
    `CHK("seq wait", 0, n)
    sync_low_req <= 1'b0;
    `WAITC("seq start", sample_start)
    `CHK("seq start", 1'b1, n < 10)
    done("sequenced sync");
    close_out();
  end
endmodule // adc_aux_function_control_tb

/* verification/host_side_model.sv */
// host and converter core stand-in facing the auxiliary block
module host_side_model
  import adc_aux_pkg::*;
#(
  parameter int CONV_LAT = 24
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic resetn,
  // bench commands
  input wire logic sync_low_req,
  input wire conv_result_t next_result,
  // block side
  input wire logic sample_start,
  output logic sync_n_pin,
  output logic core_done,
  output conv_result_t core_result
);
  timeunit 1ns;
  timeprecision 1ps;
  int low_cnt;
  int busy;
  // sync moves just after a rising edge and stays low two cycles at least
  always @(posedge clk_sys)
  begin
    if (!resetn || (!sync_low_req && (sync_n_pin || low_cnt >= 2)))
    begin
      sync_n_pin <= 1'b1;
      low_cnt <= 0;
    end
    else
    begin
      sync_n_pin <= 1'b0;
      low_cnt <= low_cnt + 1;
    end
  end
  // result a fixed time after sampling starts; junk on the bus otherwise
  always @(posedge clk_sys)
  begin
    core_done <= 1'b0;
    core_result <= ~next_result;
    if (!resetn)
      busy <= 0;
    else if (sample_start)
      busy <= CONV_LAT;
    else if (busy == 1)
    begin
      busy <= 0;
      core_done <= 1'b1;
      core_result <= next_result;
    end
    else if (busy > 1)
      busy <= busy - 1;
  end
endmodule // host_side_model
